// ---- include/ssi_consts.svh ----
`ifndef SSI_CONSTS_SVH
`define SSI_CONSTS_SVH

// ****************************************
// Byte and address layout
// ****************************************
`define SSI_DIR_BIT 7
`define SSI_PAGE_SEL_BIT 0
`define SSI_LOC_TOP 7'h7f
`define SSI_LOC_STEP 7'h01
`define SSI_LAST_BIT 3'h7
`define SSI_BIT_STEP 3'h1
`define SSI_MEM_DEPTH 256

// ****************************************
// Reset values
// ****************************************
`define SSI_RST_LOW 1'b0
`define SSI_RST_HIGH 1'b1
`define SSI_RST_LOC 7'h00
`define SSI_RST_BITS 3'h0
`define SSI_RST_BYTE 8'h00

`endif

// ---- include/ssi_pkg.sv ----
package ssi_pkg;

   // ****************************************
   // Link sequencing types
   // ****************************************
   typedef enum logic [1:0] {
      SSI_ST_CMD,
      SSI_ST_READ,
      SSI_ST_WRITE
   } ssi_state_t;

   typedef logic [7:0] ssi_byte_t;
   typedef logic [6:0] ssi_loc_t;

endpackage

// ---- src/ssi_ram.sv ----
`include "ssi_consts.svh"

module ssi_ram (
   input wire logic clk,
   input wire logic we,
   input ssi_pkg::ssi_byte_t waddr,
   input ssi_pkg::ssi_byte_t wdata,
   input ssi_pkg::ssi_byte_t raddr,
   output ssi_pkg::ssi_byte_t rdata
);
   import ssi_pkg::*;

   // ****************************************
   // Byte storage in flip-flops
   // ****************************************
   // No reset: contents are data, and clearing them would cost a wide reset tree
   ssi_byte_t mem_ff [`SSI_MEM_DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem_ff[waddr] <= wdata;
      end
   end

   // Read is combinational so a prefetch lands on the same capture edge
   assign rdata = mem_ff[raddr];

endmodule

// ---- src/ssi_sync3.sv ----
`include "ssi_consts.svh"

module ssi_sync3 (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);
   import ssi_pkg::*;

   logic stage1_ff;
   logic stage2_ff;
   logic stage3_ff;
   logic agreed_ff;

   // ****************************************
   // Three stage capture of a foreign level
   // ****************************************
   // First stage feeds only the second one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_ff <= `SSI_RST_LOW;
         stage2_ff <= `SSI_RST_LOW;
         stage3_ff <= `SSI_RST_LOW;
      end else begin
         stage1_ff <= din;
         stage2_ff <= stage1_ff;
         stage3_ff <= stage2_ff;
      end
   end

   // A change is accepted only once the last two stages agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         agreed_ff <= `SSI_RST_LOW;
      end else if (stage2_ff == stage3_ff) begin
         agreed_ff <= stage3_ff;
      end
   end

   assign dout = agreed_ff;

endmodule

// ---- src/ssi_top.sv ----
// Notes on behaviour
// RL1: Serial clock both captures MOSI bits and shifts MISO bits out.
// RL2: Every byte on both data lines moves most significant bit first.
// RL3: Slave select high keeps the serial logic in reset.
// RL4: Enable low keeps the serial logic in reset; select needs enable high, select low.
// RL5: Clock level seen when select turns true is the idle polarity for the frame.
// RL6: Capture on the edge back to idle, shift out on the opposite edge.
// RL7: One clock per bit; addresses and data move in whole bytes.
// RL8: Master clocks only while bits move and leaves the clock idle otherwise.
// RL9: Address/control byte is a direction bit plus seven location bits.
// RL10: Direction 0 starts reads, direction 1 starts writes.
// RL11: First byte after select is the address/control byte unless a page select.
// RL12: Master drops and reasserts select before each new address byte.
// RL13: Reads return data on MISO, writes take data from MOSI.
// RL14: Large version has two 128-byte pages; page byte bit 0 picks one.
// RL15: Exactly one byte in a selection marks it as a page byte.
// RL16: Master selects, sends the page byte, then deselects before more traffic.
// RL17: Page stays latched until a new page byte or a burst carry.
// RL18: Single transfer moves one byte, then the master deselects.
// RL19: Location increments after every data byte while selected.
// RL20: Address wraps to zero after 7FH (small) or FFH (large).
// RL21: Large version carries from 7FH into the page bit, reaching 80H.
// RL22: MISO stays off during writes and until a read byte is ready.
// RL23: Direction sits in bit 7, location in bits 6 to 0.
`include "ssi_consts.svh"

module ssi_top #(
   parameter bit TwoPages = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic mosi,
   input wire logic ss_n,
   input wire logic ce,
   output logic miso,
   output logic misoOe_n
);
   import ssi_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   logic selPin;
   logic selLvl;
   logic sckLvl;
   logic linkActive_ff;
   logic linkRun_ff;
   logic polarity_ff;
   logic page_ff;
   logic linkRst_n;
   logic capClk;

   ssi_state_t state_ff;
   logic [2:0] bitCnt_ff;
   logic [6:0] rxShift_ff;
   ssi_loc_t locAddr_ff;
   logic pageFlip_ff;
   logic firstDone_ff;
   logic sawExtra_ff;
   logic firstLsb_ff;
   logic linkSeen_ff;
   ssi_byte_t txByte_ff;
   logic miso_ff;
   logic misoOff_ff;

   ssi_byte_t rxByte;
   logic dirBit;
   logic byteDone;
   logic dataStep;
   logic carry;
   logic pageCur;
   logic nxt_page;
   ssi_loc_t nxt_locAddr;
   ssi_byte_t curAddr;
   ssi_byte_t ramRaddr;
   ssi_byte_t ramRdata;
   logic ramWe;

   // ****************************************
   // Reference clock side
   // ****************************************
   // Combined select: enable high and slave select low
   assign selPin = ce & ~ss_n; // RL3 RL4

   ssi_sync3 u_selSync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .din(selPin),
      .dout(selLvl)
   );

   ssi_sync3 u_sckSync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .din(sck),
      .dout(sckLvl)
   );

   // Selection tracker; the link is released one cycle after polarity settles
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         linkActive_ff <= `SSI_RST_LOW;
         linkRun_ff <= `SSI_RST_LOW;
      end else begin
         linkActive_ff <= selLvl; // RL3 RL4
         linkRun_ff <= linkActive_ff;
      end
   end

   // Idle clock level is caught as the selection turns true
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         polarity_ff <= `SSI_RST_LOW;
      end else if (selLvl && !linkActive_ff) begin
         polarity_ff <= sckLvl; // RL5
      end
   end

   // Page latch; link flags are frozen here because the serial clock is idle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         page_ff <= `SSI_RST_LOW;
      end else if (TwoPages && !selLvl && linkActive_ff) begin
         if (firstDone_ff && !sawExtra_ff) begin
            page_ff <= firstLsb_ff; // RL14 RL15
         end else begin
            page_ff <= page_ff ^ pageFlip_ff; // RL17 RL21
         end
      end
   end

   // Link logic is held in reset whenever the selection is false
   assign linkRst_n = linkRun_ff; // RL3 RL4

   // Capture edge is the return to idle; shift edge is the opposite one
   assign capClk = sck ~^ polarity_ff; // RL1 RL6

   // ****************************************
   // Link side decode
   // ****************************************
   assign rxByte = {rxShift_ff, mosi}; // RL2
   assign dirBit = rxByte[`SSI_DIR_BIT]; // RL23
   assign byteDone = (bitCnt_ff == `SSI_LAST_BIT); // RL7
   assign dataStep = byteDone && (state_ff != SSI_ST_CMD);
   assign carry = (locAddr_ff == `SSI_LOC_TOP);
   assign nxt_locAddr = locAddr_ff + `SSI_LOC_STEP; // RL20
   assign pageCur = TwoPages ? (page_ff ^ pageFlip_ff) : `SSI_RST_LOW;
   assign nxt_page = TwoPages ? (pageCur ^ carry) : `SSI_RST_LOW; // RL21
   assign curAddr = {pageCur, locAddr_ff};
   assign ramWe = dataStep && (state_ff == SSI_ST_WRITE); // RL13

   // Prefetch: first byte after the address, then the following location
   always_comb begin
      if (state_ff == SSI_ST_CMD) begin
         ramRaddr = {pageCur, rxByte[6:0]}; // RL9
      end else begin
         ramRaddr = {nxt_page, nxt_locAddr};
      end
   end

   ssi_ram u_ram (
      .clk(capClk),
      .we(ramWe),
      .waddr(curAddr),
      .wdata(rxByte),
      .raddr(ramRaddr),
      .rdata(ramRdata)
   );

   // ****************************************
   // Link side capture edge
   // ****************************************
   // Bit counter and input shifter, one bit per clock
   always_ff @(posedge capClk or negedge linkRst_n) begin
      if (!linkRst_n) begin
         bitCnt_ff <= `SSI_RST_BITS;
         rxShift_ff <= `SSI_RST_LOC;
         linkSeen_ff <= `SSI_RST_LOW;
      end else begin
         bitCnt_ff <= bitCnt_ff + `SSI_BIT_STEP; // RL7
         rxShift_ff <= rxByte[6:0]; // RL1 RL2
         linkSeen_ff <= `SSI_RST_HIGH;
      end
   end

   // Sequencer: address byte first, then data bytes in one direction
   always_ff @(posedge capClk or negedge linkRst_n) begin
      if (!linkRst_n) begin
         state_ff <= SSI_ST_CMD;
         locAddr_ff <= `SSI_RST_LOC;
      end else if (byteDone) begin
         case (state_ff)
            SSI_ST_CMD: begin
               locAddr_ff <= rxByte[6:0]; // RL9 RL11 RL23
               state_ff <= dirBit ? SSI_ST_WRITE : SSI_ST_READ; // RL10
            end
            default: begin
               locAddr_ff <= nxt_locAddr; // RL18 RL19 RL20
            end
         endcase
      end
   end

   // Page carry; kept as a toggle so the latched page is never written here
   always_ff @(posedge capClk or negedge linkRst_n) begin
      if (!linkRst_n) begin
         pageFlip_ff <= `SSI_RST_LOW;
      end else if (TwoPages && dataStep && carry) begin
         pageFlip_ff <= ~pageFlip_ff; // RL21
      end
   end

   // Byte tally for telling a page byte from an address byte
   always_ff @(posedge capClk or negedge linkRst_n) begin
      if (!linkRst_n) begin
         firstDone_ff <= `SSI_RST_LOW;
         firstLsb_ff <= `SSI_RST_LOW;
         sawExtra_ff <= `SSI_RST_LOW;
      end else begin
         if (byteDone && !firstDone_ff) begin
            firstDone_ff <= `SSI_RST_HIGH; // RL15
            firstLsb_ff <= rxByte[`SSI_PAGE_SEL_BIT]; // RL14
         end
         if (firstDone_ff) begin
            sawExtra_ff <= `SSI_RST_HIGH; // RL15
         end
      end
   end

   // Read byte loaded on the last capture edge of the previous byte
   always_ff @(posedge capClk or negedge linkRst_n) begin
      if (!linkRst_n) begin
         txByte_ff <= `SSI_RST_BYTE;
      end else if (byteDone && (dirBit || state_ff != SSI_ST_CMD)) begin
         txByte_ff <= ramRdata; // RL13
      end else if (byteDone) begin
         txByte_ff <= ramRdata; // RL13
      end
   end

   // ****************************************
   // Link side shift edge
   // ****************************************
   // Output stays off until a read byte is ready, and for all writes
   always_ff @(negedge capClk or negedge linkRst_n) begin
      if (!linkRst_n) begin
         misoOff_ff <= `SSI_RST_HIGH;
         miso_ff <= `SSI_RST_LOW;
      end else begin
         misoOff_ff <= (state_ff != SSI_ST_READ); // RL22
         miso_ff <= txByte_ff[~bitCnt_ff]; // RL1 RL2 RL6
      end
   end

   assign miso = miso_ff;
   assign misoOe_n = misoOff_ff;

   // ****************************************
   // Checks on the reference clock side
   // ****************************************
   polarity_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL5
      (linkActive_ff && $past(linkActive_ff)) |-> $stable(polarity_ff))
      else $error("Idle polarity changed during a selection");

   polarity_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL5
      $rose(linkActive_ff) |-> (polarity_ff == $past(sckLvl)))
      else $error("Idle polarity not taken from clock level at select");

   link_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL3 RL4
      !selLvl |-> ##2 !linkRun_ff)
      else $error("Link logic not held in reset while deselected");

   page_select_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL15
      (TwoPages && !selLvl && linkActive_ff && firstDone_ff && !sawExtra_ff)
      |=> (page_ff == $past(firstLsb_ff)))
      else $error("Single byte selection did not load the page bit");

   page_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL17
      !(!selLvl && linkActive_ff) |=> $stable(page_ff))
      else $error("Page bit changed outside a deselection");

   sel_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL3 RL4
      (selLvl && linkActive_ff) |=> linkRun_ff)
      else $error("Link logic held in reset while selected");

   // ****************************************
   // Checks on the link side
   // ****************************************
   bit_count_a: assert property (@(posedge capClk) disable iff (!linkRst_n) // RL7
      linkSeen_ff |-> (bitCnt_ff == $past(bitCnt_ff) + `SSI_BIT_STEP))
      else $error("Bit counter did not advance by one");

   dir_decode_a: assert property (@(posedge capClk) disable iff (!linkRst_n) // RL10
      (linkSeen_ff && $past(byteDone) && $past(state_ff) == SSI_ST_CMD)
      |-> (state_ff == ($past(dirBit) ? SSI_ST_WRITE : SSI_ST_READ)))
      else $error("Direction bit decoded wrongly");

   addr_step_a: assert property (@(posedge capClk) disable iff (!linkRst_n) // RL19
      (linkSeen_ff && $past(dataStep))
      |-> (locAddr_ff == $past(locAddr_ff) + `SSI_LOC_STEP))
      else $error("Location did not increment after a data byte");

   page_carry_a: assert property (@(posedge capClk) disable iff (!linkRst_n) // RL21
      (TwoPages && linkSeen_ff && $past(dataStep) && $past(carry))
      |-> (pageFlip_ff != $past(pageFlip_ff)) && (locAddr_ff == `SSI_RST_LOC))
      else $error("Page carry missing past the top location");

   miso_off_a: assert property (@(posedge capClk) disable iff (!linkRst_n) // RL22
      (state_ff != SSI_ST_READ) |-> misoOff_ff)
      else $error("MISO driven outside a read");

   first_byte_a: assert property (@(posedge capClk) disable iff (!linkRst_n) // RL11
      (byteDone && !firstDone_ff) |-> (state_ff == SSI_ST_CMD))
      else $error("First byte not taken as address byte");

   cmd_load_a: assert property (@(posedge capClk) disable iff (!linkRst_n) // RL9 RL23
      (linkSeen_ff && $past(byteDone) && $past(state_ff) == SSI_ST_CMD)
      |-> (locAddr_ff == $past(rxByte[6:0])))
      else $error("Location not taken from the address byte");

   wrap_zero_a: assert property (@(posedge capClk) disable iff (!linkRst_n) // RL20
      (linkSeen_ff && $past(dataStep) && $past(locAddr_ff) == `SSI_LOC_TOP)
      |-> (locAddr_ff == `SSI_RST_LOC))
      else $error("Location did not wrap to zero after the top");

   read_drive_a: assert property (@(posedge capClk) disable iff (!linkRst_n) // RL22
      (state_ff == SSI_ST_READ && $past(state_ff) == SSI_ST_READ) |-> !misoOff_ff)
      else $error("MISO not driven during read data");

   shift_out_a: assert property (@(posedge capClk) disable iff (!linkRst_n) // RL2 RL6
      !misoOff_ff |-> (miso_ff == txByte_ff[~bitCnt_ff]))
      else $error("Read bit shifted out of order");

endmodule

// ---- tb/ssi_spi_master.sv ----
// ****************************************
// Serial bus master model
// ****************************************
module ssi_spi_master
   import ssi_pkg::*;
(
   output logic sck,
   output logic mosi,
   output logic ss_n,
   output logic ce,
   input wire logic miso,
   input wire logic misoOe_n
);
   timeunit 1ns;
   timeprecision 100ps;

   ssi_byte_t txB [0:7];
   ssi_byte_t rxB [0:7];
   logic oeLow [0:7];

   // Idle bus at time zero, device deselected
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
      ss_n = 1'b1;
      ce = 1'b0;
   end

   // One selection: idle level set while deselected, then whole bytes, then release
   task automatic frame(input logic pol, input int nBits, input logic ceOn, input logic selOn);
      int i;
      for (i = 0; i < 8; i++) begin
         oeLow[i] = 1'b0;
      end
      sck = pol;
      #20;
      ce = ceOn;
      ss_n = ~selOn;
      #150;
      for (i = 0; i < nBits; i++) begin
         // Data moves a quarter period after the capture edge, never in its time step
         #3.75 mosi = txB[i / 8][7 - i % 8];
         #3.75 sck = ~pol;
         #7.5;
         // A released line reads back inverted, so a late enable shows as bad data
         rxB[i / 8][7 - i % 8] = misoOe_n ? ~miso : miso;
         oeLow[i / 8] = oeLow[i / 8] | ~misoOe_n;
         sck = pol;
      end
      // Clock stays idle for the hold time before select drops
      #150;
      mosi = ~mosi;
      ss_n = 1'b1;
      ce = 1'b0;
      #120;
   endtask
endmodule

// ---- tb/testbench.sv ----
// ****************************************
// Serial RAM slave bench
// ****************************************
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import ssi_pkg::*;

   logic ref_clk;
   logic rst_n;
   wire logic sck;
   wire logic mosi;
   wire logic ss_n;
   wire logic ce;
   logic miso;
   logic misoOe_n;
   int err_total;
   int cmp_count;
   logic [31:0] lfsrQ = 32'hd1e6;
   ssi_byte_t mem [0:255];
   logic [7:0] cursor;
   logic expPage;
   ssi_byte_t b;
   logic pol;
   logic pg;

   ssi_top #(.TwoPages(1'b1)) uut (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .sck(sck),
      .mosi(mosi),
      .ss_n(ss_n),
      .ce(ce),
      .miso(miso),
      .misoOe_n(misoOe_n)
   );

   ssi_spi_master master (
      .sck(sck),
      .mosi(mosi),
      .ss_n(ss_n),
      .ce(ce),
      .miso(miso),
      .misoOe_n(misoOe_n)
   );

   // 100 MHz system clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Two-page counter: 7F carries into the page, FF wraps to 00
   function automatic logic [7:0] nextLoc(input logic [7:0] a);
      return a + 8'h01;
   endfunction

   // Eight LFSR steps per byte so successive bytes share no shifted bits
   function automatic ssi_byte_t rnd();
      repeat (8) lfsrQ = {lfsrQ[30:0], lfsrQ[31] ^ lfsrQ[21] ^ lfsrQ[1] ^ lfsrQ[0]};
      return lfsrQ[7:0];
   endfunction

   task automatic chk(input string what, input logic [7:0] expV, input logic [7:0] gotV);
      cmp_count++;
      if (gotV !== expV) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, expV, gotV);
      end
   endtask

   // Page byte with random ignored upper bits
   task automatic pageSel(input logic p, input logic p2);
      ssi_byte_t v;
      v = rnd();
      master.txB[0] = {v[7:1], p2};
      master.frame(p, 8, 1'b1, 1'b1);
      expPage = p2;
   endtask

   task automatic wrBurst(input logic p, input logic [6:0] loc, input int n);
      ssi_byte_t v;
      master.txB[0] = {1'b1, loc};
      cursor = {expPage, loc};
      for (int i = 1; i <= n; i++) begin
         v = rnd();
         master.txB[i] = v;
         mem[cursor] = v;
         cursor = nextLoc(cursor);
      end
      master.frame(p, 8 * (n + 1), 1'b1, 1'b1);
      expPage = cursor[7];
      for (int i = 0; i <= n; i++) begin
         chk("miso enable on write", 8'h00, {7'h00, master.oeLow[i]});
      end
   endtask

   task automatic rdBurst(input logic p, input logic [6:0] loc, input int n);
      ssi_byte_t v;
      master.txB[0] = {1'b0, loc};
      cursor = {expPage, loc};
      for (int i = 1; i <= n; i++) begin
         v = rnd();
         master.txB[i] = v;
      end
      master.frame(p, 8 * (n + 1), 1'b1, 1'b1);
      chk("miso enable in address byte", 8'h00, {7'h00, master.oeLow[0]});
      for (int i = 1; i <= n; i++) begin
         chk("read data", mem[cursor], master.rxB[i]);
         chk("miso enable on read", 8'h01, {7'h00, master.oeLow[i]});
         cursor = nextLoc(cursor);
      end
      expPage = cursor[7];
   endtask

   task automatic report_and_stop;
      $display("Compares %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Hang guard: bounded count of system clocks
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      report_and_stop();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rst_n = 1'b0;
      err_total = 0;
      cmp_count = 0;
      repeat (16) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      expPage = 1'b0;
      // Burst across the page boundary, then the carried page stays latched
      wrBurst(1'b0, 7'h7d, 4);
      rdBurst(1'b1, 7'h00, 1);
      pageSel(1'b0, 1'b0);
      rdBurst(1'b1, 7'h7d, 4);
      // Top of the two-page space wraps to zero
      pageSel(1'b0, 1'b1);
      wrBurst(1'b1, 7'h7e, 3);
      pageSel(1'b1, 1'b1);
      rdBurst(1'b0, 7'h7e, 3);
      // Traffic while enable is low or select is high must write nothing
      master.txB[0] = {1'b1, 7'h7e};
      master.txB[1] = ~mem[8'hfe];
      master.frame(1'b0, 16, 1'b0, 1'b1);
      master.frame(1'b0, 16, 1'b1, 1'b0);
      pageSel(1'b1, 1'b1);
      rdBurst(1'b1, 7'h7e, 1);
      // Random single-byte write and read-back
      repeat (8) begin
         b = rnd();
         pol = b[0];
         pg = b[7];
         b = rnd();
         pageSel(pol, pg);
         wrBurst(pol, b[6:0], 1);
         pageSel(~pol, pg);
         rdBurst(~pol, b[6:0], 1);
      end
      report_and_stop();
   end
endmodule
